// ===== core/adcsq_top.sv
// sequencer control block of a 10-bit converter: apb registers, trigger, arbitration, sequencing, averaging
// assumes the converter answers each start pulse with a done pulse on pclk, trigger pins are asynchronous
//
// Summary of operation
// - four sequencers, depths eight four four one
// - fifo word is 32 bits, result low ten
// - step uses input nibble and control nibble
// - sequencer runs only while enable bit set
// - same input may repeat within a sequence
// - raw interrupt after each step with enable
// - sequence stops after step marked end
// - fifo circular, each read pops oldest
// - fifo status shows pointers, full, empty
// - overflow and underflow flags readable separately
// - control runs at divided converter rate
// - mask gates interrupt to the controller
// - raw shows all, clear register shows masked
// - writing one clears interrupt, zero ignored
// - concurrent triggers served by priority zero first
// - trigger source selectable, processor and always
// - initiate bit starts processor-triggered sequencer
// - averager folds up to 64 conversions
// - averager bypassed after reset, shared by all
// - single-ended code spans 0x000 to 0x3ff
// - differential select names even-odd input pair
`timescale 1ns/1ps
`default_nettype none
`include "adcsq_map.svh"

module adcsq_top #(
  parameter int RES_W = 10
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic                  pready,
  output logic      [31:0]      prdata,
  output logic                  pslverr,
  // external trigger pins
  input  wire logic [3:0]       trig_in,
  // converter
  output logic                  conv_start,
  output logic      [3:0]       conv_pos,
  output logic      [3:0]       conv_neg,
  output logic                  conv_diff,
  output logic                  conv_temp,
  input  wire logic             conv_done,
  input  wire logic [RES_W-1:0] conv_data,
  // interrupt lines, one per sequencer
  output logic      [3:0]       irq
);
  import adcsq_pkg::*;

  // ************************************************************
  // constants
  // ************************************************************
  localparam int         DIV_INT = (`ADCSQ_PCLK_HZ + `ADCSQ_CONV_CLK_HZ / 2) / `ADCSQ_CONV_CLK_HZ;
  localparam logic [2:0] DIV_MAX = 3'(DIV_INT - 1);  // divider terminal count

  // ************************************************************
  // state and fifo wiring
  // ************************************************************
  adcsq_state_s_t         s_q;        // registered state
  adcsq_state_s_t         s_d;        // next state
  logic [3:0]             fifo_push;  // push strobe per fifo
  logic [RES_W-1:0]       push_data;  // shared result word
  logic [3:0]             fifo_pop;   // pop strobe per fifo
  logic [3:0][RES_W-1:0]  fifo_data;  // oldest entries
  logic [3:0][3:0]        fifo_head;  // write pointers
  logic [3:0][3:0]        fifo_tail;  // read pointers
  logic [3:0]             fifo_full;  // full flags
  logic [3:0]             fifo_empty; // empty flags

  // one result fifo per sequencer, depth set per index
  for (genvar g = 0; g < 4; g++)
  begin : g_fifo
    adcsq_fifo #(
      .DEPTH (g == 0 ? `ADCSQ_DEPTH0 : g == 1 ? `ADCSQ_DEPTH1 : g == 2 ? `ADCSQ_DEPTH2 : `ADCSQ_DEPTH3),
      .W     (RES_W)
    ) u_fifo (
      .pclk      (pclk),
      .presetn   (presetn),
      .push      (fifo_push[g]),
      .push_data (push_data),
      .pop       (fifo_pop[g]),
      .pop_data  (fifo_data[g]),
      .head      (fifo_head[g]),
      .tail      (fifo_tail[g]),
      .full      (fifo_full[g]),
      .empty     (fifo_empty[g])
    );
  end

  // last step index available in a sequencer
  function automatic logic [2:0] last_step(input logic [1:0] idx);
    case (idx)
      2'd0:    last_step = 3'(`ADCSQ_DEPTH0 - 1);
      2'd1:    last_step = 3'(`ADCSQ_DEPTH1 - 1);
      2'd2:    last_step = 3'(`ADCSQ_DEPTH2 - 1);
      default: last_step = 3'(`ADCSQ_DEPTH3 - 1);
    endcase
  endfunction

  // ************************************************************
  // outputs
  // ************************************************************
  assign pready     = 1'b1;
  assign prdata     = s_q.prdata;
  assign pslverr    = s_q.pslverr;
  assign conv_start = s_q.conv_start;
  assign conv_pos   = s_q.conv_pos;
  assign conv_neg   = s_q.conv_neg;
  assign conv_diff  = s_q.conv_diff;
  assign conv_temp  = s_q.conv_temp;
  assign irq        = s_q.raw & s_q.mask;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    logic        tick;      // conversion clock enable
    logic        setup;     // apb setup phase
    logic        wr;        // apb write completes
    logic        rd;        // apb read completes
    logic        in_seq;    // address inside per-sequencer groups
    logic [7:0]  sub;       // offset inside groups
    logic [1:0]  sn;        // addressed sequencer
    logic [2:0]  sr;        // addressed register within group
    logic [3:0]  cand;      // enabled sequencers with a trigger
    logic        found;     // arbitration winner found
    logic [1:0]  win;       // arbitration winner
    logic [3:0]  nib_in;    // current step input nibble
    logic [3:0]  nib_ctl;   // current step control nibble
    logic [2:0]  avg_e;     // clamped averaging exponent
    logic [15:0] sum;       // accumulator plus new result
    logic [3:0]  tsel;      // trigger select of one sequencer
    tick      = 1'b0;
    setup     = 1'b0;
    wr        = 1'b0;
    rd        = 1'b0;
    in_seq    = 1'b0;
    sub       = 8'h00;
    sn        = 2'd0;
    sr        = 3'd0;
    cand      = 4'h0;
    found     = 1'b0;
    win       = 2'd0;
    nib_in    = 4'h0;
    nib_ctl   = 4'h0;
    avg_e     = 3'd0;
    sum       = 16'h0000;
    tsel      = 4'h0;
    s_d       = s_q;
    fifo_push = 4'h0;
    fifo_pop  = 4'h0;
    push_data = '0;
    s_d.conv_start = 1'b0;

    // conversion clock enable from the divider
    tick    = s_q.div == DIV_MAX;
    s_d.div = tick ? 3'd0 : s_q.div + 3'd1;

    // decode of the apb address
    setup  = psel && !penable;
    wr     = psel && penable && pwrite;
    rd     = psel && penable && !pwrite;
    in_seq = paddr >= `ADCSQ_OFS_SEQ_BASE && paddr < `ADCSQ_OFS_SEQ_END;
    sub    = 8'(paddr - `ADCSQ_OFS_SEQ_BASE);
    sn     = sub[6:5];
    sr     = sub[4:2];

    // register writes; clears first so hardware sets below win
    if (wr)
    begin
      if (paddr == `ADCSQ_OFS_ENABLE)
        s_d.enable = pwdata[3:0];
      else if (paddr == `ADCSQ_OFS_MASK)
        s_d.mask = pwdata[3:0];
      else if (paddr == `ADCSQ_OFS_ISC)
        s_d.raw = s_q.raw & ~pwdata[3:0];
      else if (paddr == `ADCSQ_OFS_OVF)
        s_d.ovf = s_q.ovf & ~pwdata[3:0];
      else if (paddr == `ADCSQ_OFS_EMUX)
        s_d.emux = pwdata[15:0];
      else if (paddr == `ADCSQ_OFS_UNF)
        s_d.unf = s_q.unf & ~pwdata[3:0];
      else if (paddr == `ADCSQ_OFS_PRI)
        s_d.pri = pwdata[15:0] & `ADCSQ_PRI_MASK;
      else if (paddr == `ADCSQ_OFS_AVG)
        s_d.avg = pwdata[2:0];
      else if (in_seq && sr == `ADCSQ_SEQ_MUX)
        s_d.mux[sn] = pwdata;
      else if (in_seq && sr == `ADCSQ_SEQ_CTL)
        s_d.ctl[sn] = pwdata;
    end

    // fifo read pops the oldest entry, or flags an empty read
    if (rd && in_seq && sr == `ADCSQ_SEQ_FIFO)
    begin
      fifo_pop[sn] = 1'b1;
      if (fifo_empty[sn])
        s_d.unf[sn] = 1'b1;
    end

    // trigger sources per sequencer
    s_d.sync1     = trig_in;
    s_d.sync2     = s_q.sync1;
    s_d.trig_prev = s_q.sync2;
    for (int i = 0; i < 4; i++)
    begin
      tsel = s_q.emux[i*4 +: 4];
      if (tsel == `ADCSQ_TRIG_ALWAYS)
        s_d.pend[i] = 1'b1;
      else if (tsel >= `ADCSQ_TRIG_EXT_LO && tsel <= `ADCSQ_TRIG_EXT_HI)
      begin
        if (s_q.sync2[tsel[1:0] - 2'd1] && !s_q.trig_prev[tsel[1:0] - 2'd1])
          s_d.pend[i] = 1'b1;
      end
      else if (tsel == `ADCSQ_TRIG_PROC && wr && paddr == `ADCSQ_OFS_INIT && pwdata[i])
        s_d.pend[i] = 1'b1;
    end

    // arbitration: lowest priority value wins, lowest index on a tie
    cand = s_q.enable & s_q.pend;
    for (int l = 0; l < 4; l++)
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (!found && cand[i] && s_q.pri[i*4 +: 2] == 2'(l))
        begin
          found = 1'b1;
          win   = 2'(i);
        end
      end
    end

    // current step nibbles; any input may recur in a sequence
    nib_in  = 4'(s_q.mux[s_q.cur] >> {s_q.step, 2'b00});
    nib_ctl = 4'(s_q.ctl[s_q.cur] >> {s_q.step, 2'b00});
    avg_e   = (s_q.avg > `ADCSQ_AVG_MAX) ? `ADCSQ_AVG_MAX : s_q.avg;
    sum     = s_q.acc + 16'(conv_data);

    // sequence walk
    case (s_q.state)
      ADCSQ_IDLE:
      begin
        s_d.acc  = 16'h0000;
        s_d.navg = 7'h00;
        if (tick && found)
        begin
          s_d.cur       = win;
          s_d.step      = 3'd0;
          s_d.pend[win] = 1'b0;
          s_d.state     = ADCSQ_START;
        end
      end
      ADCSQ_START:
      begin
        if (!s_q.enable[s_q.cur])
          s_d.state = ADCSQ_IDLE;
        else if (tick)
        begin
          s_d.conv_start = 1'b1;
          s_d.conv_diff  = nib_ctl[`ADCSQ_CTL_DIFF];
          s_d.conv_temp  = nib_ctl[`ADCSQ_CTL_TEMP];
          if (nib_ctl[`ADCSQ_CTL_DIFF])
          begin
            s_d.conv_pos = {nib_in[2:0], 1'b0};
            s_d.conv_neg = {nib_in[2:0], 1'b1};
          end
          else
          begin
            s_d.conv_pos = nib_in;
            s_d.conv_neg = 4'h0;
          end
          s_d.state = ADCSQ_WAIT;
        end
      end
      ADCSQ_WAIT:
      begin
        if (conv_done)
        begin
          if (s_q.navg + 7'h01 == 7'(1 << avg_e))
          begin
            push_data         = RES_W'(sum >> avg_e);
            fifo_push[s_q.cur] = 1'b1;
            if (fifo_full[s_q.cur])
              s_d.ovf[s_q.cur] = 1'b1;
            if (nib_ctl[`ADCSQ_CTL_IE])
              s_d.raw[s_q.cur] = 1'b1;
            s_d.acc  = 16'h0000;
            s_d.navg = 7'h00;
            if (nib_ctl[`ADCSQ_CTL_END] || s_q.step == last_step(s_q.cur))
              s_d.state = ADCSQ_IDLE;
            else
            begin
              s_d.step  = s_q.step + 3'd1;
              s_d.state = ADCSQ_START;
            end
          end
          else
          begin
            s_d.acc   = sum;
            s_d.navg  = s_q.navg + 7'h01;
            s_d.state = ADCSQ_START;
          end
        end
      end
      default:
        s_d.state = ADCSQ_IDLE;
    endcase

    // read data captured in the setup phase
    if (setup)
    begin
      s_d.prdata  = 32'h0000_0000;
      s_d.pslverr = 1'b0;
      if (paddr == `ADCSQ_OFS_ENABLE)
        s_d.prdata[3:0] = s_q.enable;
      else if (paddr == `ADCSQ_OFS_RAW)
        s_d.prdata[3:0] = s_q.raw;
      else if (paddr == `ADCSQ_OFS_MASK)
        s_d.prdata[3:0] = s_q.mask;
      else if (paddr == `ADCSQ_OFS_ISC)
        s_d.prdata[3:0] = s_q.raw & s_q.mask;
      else if (paddr == `ADCSQ_OFS_OVF)
        s_d.prdata[3:0] = s_q.ovf;
      else if (paddr == `ADCSQ_OFS_EMUX)
        s_d.prdata[15:0] = s_q.emux;
      else if (paddr == `ADCSQ_OFS_UNF)
        s_d.prdata[3:0] = s_q.unf;
      else if (paddr == `ADCSQ_OFS_PRI)
        s_d.prdata[15:0] = s_q.pri;
      else if (paddr == `ADCSQ_OFS_INIT)
        s_d.prdata = 32'h0000_0000;
      else if (paddr == `ADCSQ_OFS_AVG)
        s_d.prdata[2:0] = s_q.avg;
      else if (in_seq && sr == `ADCSQ_SEQ_MUX)
        s_d.prdata = s_q.mux[sn];
      else if (in_seq && sr == `ADCSQ_SEQ_CTL)
        s_d.prdata = s_q.ctl[sn];
      else if (in_seq && sr == `ADCSQ_SEQ_FIFO)
        s_d.prdata[RES_W-1:0] = fifo_data[sn];
      else if (in_seq && sr == `ADCSQ_SEQ_FSTAT)
        s_d.prdata[12:0] = {fifo_full[sn], 3'h0, fifo_empty[sn], fifo_head[sn], fifo_tail[sn]};
      else
        s_d.pslverr = 1'b1;
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q       <= '0;
      s_q.pri   <= `ADCSQ_PRI_RESET;
      s_q.state <= ADCSQ_IDLE;
    end
    else
      s_q <= s_d;
  end

endmodule // adcsq_top
`default_nettype wire

// ===== core/adcsq_map.svh
// register offsets, field positions, reset values and clock rates of the sequencer control block
// assumes inclusion by bare name from the package and the design files
`ifndef ADCSQ_MAP_SVH
`define ADCSQ_MAP_SVH

// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define ADCSQ_OFS_ENABLE     12'h000
`define ADCSQ_OFS_RAW        12'h004
`define ADCSQ_OFS_MASK       12'h008
`define ADCSQ_OFS_ISC        12'h00c
`define ADCSQ_OFS_OVF        12'h010
`define ADCSQ_OFS_EMUX       12'h014
`define ADCSQ_OFS_UNF        12'h018
`define ADCSQ_OFS_PRI        12'h020
`define ADCSQ_OFS_INIT       12'h028
`define ADCSQ_OFS_AVG        12'h030
`define ADCSQ_OFS_SEQ_BASE   12'h040
`define ADCSQ_OFS_SEQ_END    12'h0c0
// register index inside one per-sequencer group of 0x20 bytes
`define ADCSQ_SEQ_MUX        3'h0
`define ADCSQ_SEQ_CTL        3'h1
`define ADCSQ_SEQ_FIFO       3'h2
`define ADCSQ_SEQ_FSTAT      3'h3

// ************************************************************
// fields and reset values
// ************************************************************
`define ADCSQ_CTL_DIFF       0
`define ADCSQ_CTL_END        1
`define ADCSQ_CTL_IE         2
`define ADCSQ_CTL_TEMP       3
`define ADCSQ_TRIG_PROC      4'h0
`define ADCSQ_TRIG_EXT_LO    4'h1
`define ADCSQ_TRIG_EXT_HI    4'h4
`define ADCSQ_TRIG_ALWAYS    4'hf
`define ADCSQ_PRI_RESET      16'h3210
`define ADCSQ_PRI_MASK       16'h3333
`define ADCSQ_AVG_MAX        3'h6
`define ADCSQ_DEPTH0         8
`define ADCSQ_DEPTH1         4
`define ADCSQ_DEPTH2         4
`define ADCSQ_DEPTH3         1

// ************************************************************
// timing
// ************************************************************
`define ADCSQ_PCLK_HZ        100000000
`define ADCSQ_CONV_CLK_HZ    16667000

`endif

// ===== core/adcsq_pkg.sv
// types of the sequencer control block
// assumes the map header is on the include path
`include "adcsq_map.svh"

package adcsq_pkg;

  // sequencer walk state
  typedef enum logic [1:0] {
    ADCSQ_IDLE,
    ADCSQ_START,
    ADCSQ_WAIT
  } adcsq_state_t;

  // complete state of the control block
  typedef struct packed {
    logic [3:0]        enable;     // sequencer enable bits
    logic [3:0]        mask;       // interrupt mask
    logic [3:0]        raw;        // raw interrupt status
    logic [3:0]        ovf;        // overflow flags
    logic [3:0]        unf;        // underflow flags
    logic [15:0]       emux;       // trigger select nibbles
    logic [15:0]       pri;        // priority fields
    logic [2:0]        avg;        // averaging exponent
    logic [3:0][31:0]  mux;        // step input nibbles
    logic [3:0][31:0]  ctl;        // step control nibbles
    logic [3:0]        pend;       // pending triggers
    logic [3:0]        sync1;      // trigger synchroniser stage 1
    logic [3:0]        sync2;      // trigger synchroniser stage 2
    logic [3:0]        trig_prev;  // edge detect history
    adcsq_state_t      state;      // walk state
    logic [1:0]        cur;        // sequencer being served
    logic [2:0]        step;       // step within sequence
    logic [15:0]       acc;        // averaging accumulator
    logic [6:0]        navg;       // conversions accumulated
    logic [2:0]        div;        // conversion clock divider
    logic [31:0]       prdata;     // read data
    logic              pslverr;    // error answer
    logic              conv_start; // start pulse
    logic [3:0]        conv_pos;   // positive input select
    logic [3:0]        conv_neg;   // negative input select
    logic              conv_diff;  // differential conversion
    logic              conv_temp;  // temperature sensor select
  } adcsq_state_s_t;

endpackage

// ===== core/adcsq_fifo.sv
// circular result fifo of one sequencer
// assumes push and pop come from logic on pclk
`timescale 1ns/1ps
`default_nettype none

module adcsq_fifo #(
  parameter int DEPTH = 8,
  parameter int W     = 10
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // write side
  input  wire logic         push,
  input  wire logic [W-1:0] push_data,
  // read side
  input  wire logic         pop,
  output logic      [W-1:0] pop_data,
  // status
  output logic      [3:0]   head,
  output logic      [3:0]   tail,
  output logic              full,
  output logic              empty
);
  import adcsq_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;   // entries
    logic [3:0]              head;  // write pointer
    logic [3:0]              tail;  // read pointer
    logic [4:0]              count; // entries held
  } adcsq_fifo_st_t;

  adcsq_fifo_st_t s_q;  // registered state
  adcsq_fifo_st_t s_d;  // next state

  localparam logic [3:0] LAST = 4'(DEPTH - 1);  // last pointer value
  localparam logic [4:0] FULL = 5'(DEPTH);      // count when full

  assign full     = s_q.count == FULL;
  assign empty    = s_q.count == 5'h00;
  assign head     = s_q.head;
  assign tail     = s_q.tail;
  assign pop_data = s_q.mem[s_q.tail[$clog2(DEPTH+1)-1:0] % DEPTH];

  // push when room, pop when data; a push into a full fifo is dropped
  always_comb
  begin
    s_d = s_q;
    if (push && !full)
    begin
      s_d.mem[s_q.head % DEPTH] = push_data;
      s_d.head                  = (s_q.head == LAST) ? 4'h0 : s_q.head + 4'h1;
    end
    if (pop && !empty)
    begin
      s_d.tail = (s_q.tail == LAST) ? 4'h0 : s_q.tail + 4'h1;
    end
    s_d.count = s_q.count + 5'((push && !full) ? 1 : 0) - 5'((pop && !empty) ? 1 : 0);
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

endmodule // adcsq_fifo
`default_nettype wire

// ===== bench/adcsq_top_properties.sv
// assertions on the ports of the sequencer control block
// assumes a bind onto adcsq_top, pclk domain only
`timescale 1ns/1ps
`default_nettype none
module adcsq_top_properties (
  // clock, reset, bus
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // converter, interrupts
  input wire logic        conv_start,
  input wire logic [3:0]  conv_pos,
  input wire logic [3:0]  conv_neg,
  input wire logic        conv_diff,
  input wire logic        conv_done,
  input wire logic [3:0]  irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr; // write access cycle
  assign wr = psel && penable && pwrite;
  chk_start_gap: assert property (conv_start |=> !conv_start [*5])
    else $error("starts too close");
  chk_sel_hold: assert property (!conv_start |-> $stable({conv_pos, conv_neg, conv_diff}))
    else $error("selects moved");
  chk_pair_sel: assert property (conv_start && conv_diff |-> !conv_pos[0] && conv_neg == conv_pos + 4'h1)
    else $error("bad input pair");
  chk_irq_cause: assert property ((irq & ~$past(irq)) != 4'h0
    |-> $past(conv_done) || $past(wr) && $past(paddr) == 12'h008) else $error("irq without cause");
  chk_mask_gate: assert property (wr && paddr == 12'h008 |=> (irq & ~$past(pwdata[3:0])) == 4'h0)
    else $error("masked irq high");
  chk_clear_one: assert property (wr && paddr == 12'h00c && !conv_done |=> (irq & $past(pwdata[3:0])) == 4'h0)
    else $error("irq not cleared");
  chk_zero_keep: assert property (wr && paddr == 12'h00c |=> (~irq & $past(irq) & ~$past(pwdata[3:0])) == 4'h0)
    else $error("irq lost on zero write");
  chk_stop_off: assert property (wr && paddr == 12'h000 && pwdata[3:0] == 4'h0 |=> ##1 !conv_start [*8])
    else $error("start while disabled");
  cover property (conv_start && conv_diff);
  cover property (irq != 4'h0);
  cover property (wr && paddr == 12'h00c && pwdata[3:0] == 4'h0);
endmodule // adcsq_top_properties
bind adcsq_top adcsq_top_properties u_adcsq_top_properties (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .conv_start(conv_start),
  .conv_pos(conv_pos), .conv_neg(conv_neg), .conv_diff(conv_diff), .conv_done(conv_done), .irq(irq));
`default_nettype wire

// ===== bench/adcsq_conv_model.sv
// converter model: one done pulse per start, lat+1 cycles after the start is sampled
// assumes starts on pclk, lat held by the bench
`timescale 1ns/1ps
`default_nettype none
module adcsq_conv_model (
  // clock, reset, selects
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       conv_start,
  input  wire logic [3:0] conv_pos,
  input  wire logic [3:0] conv_neg,
  input  wire logic       conv_diff,
  input  wire logic       conv_temp,
  input  wire logic [2:0] lat,
  // result
  output var logic        conv_done,
  output var logic [9:0]  conv_data
);
  logic [9:0] code_q; // code in flight
  int         cnt_q;  // cycles left, -1 idle
  // data toggles outside the done pulse
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      conv_done <= 1'b0;
      conv_data <= 10'h155;
      cnt_q     <= -1;
    end
    else
    begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      if (conv_start)
      begin
        code_q <= {conv_diff, conv_temp, conv_pos, conv_diff ? conv_neg : 4'h0};
        cnt_q  <= int'(lat);
      end
      else if (cnt_q >= 0)
        cnt_q <= cnt_q - 1;
      if (!conv_start && cnt_q == 0)
      begin
        conv_done <= 1'b1;
        conv_data <= code_q;
      end
    end
  end
endmodule // adcsq_conv_model
`default_nettype wire

// ===== bench/testbench.sv
// bench of the sequencer control block against a queue model
// assumes the converter model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, conv_start, conv_diff, conv_temp, conv_done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0]  trig_in, conv_pos, conv_neg, irq, raw_m, ovf_m;
  logic [9:0]  conv_data;
  logic [2:0]  lat;
  logic [3:0]  pos_q[$];  // select at each start
  int exp_q[4][$];        // model fifo words
  int dep[4] = '{8, 4, 4, 1};
  int error_cnt, comparisons, seed, cyc, starts, t0;
  adcsq_top u_adcsq_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .trig_in(trig_in),
    .conv_start(conv_start), .conv_pos(conv_pos), .conv_neg(conv_neg), .conv_diff(conv_diff),
    .conv_temp(conv_temp), .conv_done(conv_done), .conv_data(conv_data), .irq(irq));
  adcsq_conv_model u_adcsq_conv_model (.pclk(pclk), .presetn(presetn), .conv_start(conv_start),
    .conv_pos(conv_pos), .conv_neg(conv_neg), .conv_diff(conv_diff), .conv_temp(conv_temp), .lat(lat),
    .conv_done(conv_done), .conv_data(conv_data));
  always #5 pclk = ~pclk;
  // start monitor and watchdog
  always @(posedge pclk)
  begin
    cyc++;
    if (conv_start)
    begin
      pos_q.push_back(conv_pos);
      starts++;
    end
    if (cyc == 20000)
    begin
      error_cnt++;
      results;
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rdat & m, e);
  endtask
  // program n steps and extend the model
  task cfg(input int s, input int n);
    logic [31:0] m, c;
    logic [3:0] p;
    int k;
    m = $random(seed);
    c = 0;
    for (k = 0; k < n; k++)
    begin
      m[4*k+:4] = m[4*k+:4] & 4'h3;
      c[4*k+:4] = 4'(($random(seed) & 13) | (k == n - 1 ? 6 : 0));
      p = c[4*k] ? {m[4*k+:3], 1'b0} : m[4*k+:4];
      if (exp_q[s].size() < dep[s]) exp_q[s].push_back({c[4*k], c[4*k+3], p, c[4*k] ? p + 4'h1 : 4'h0});
      else ovf_m[s] = 1'b1;
      raw_m[s] = 1'b1;
    end
    apb(1'b1, 12'h040 + 12'(32 * s), m);
    apb(1'b1, 12'h044 + 12'(32 * s), c);
  endtask
  task go(input logic [3:0] en, input logic [3:0] ini, input int n);
    int s0;
    int k;
    s0 = starts;
    apb(1'b1, 12'h028, {28'h0, ini});
    apb(1'b1, 12'h000, {28'h0, en});
    for (k = 0; k < 600 && starts < s0 + n; k++) @(posedge pclk);
    repeat (60) @(posedge pclk);
    check(starts - s0, n);
  endtask
  // pop all, then once more while empty
  task drain(input int s);
    logic [11:0] b;
    b = 12'h040 + 12'(32 * s);
    while (exp_q[s].size() > 0) rd(b + 12'h8, 32'hffffffff, exp_q[s].pop_front());
    rd(b + 12'hc, 32'h1100, 32'h100);
    rd(b + 12'h8, 32'hfffffc00, 32'h0);
    rd(12'h018, 32'hf, 32'(1 << s));
    apb(1'b1, 12'h018, 32'hf);
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, trig_in, lat, raw_m, ovf_m} = '0;
    seed = 32'h1aec;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h020, 32'hffffffff, 32'h3210);
    rd(12'h030, 32'hffffffff, 32'h0);
    rd(12'h01c, 32'hffffffff, 32'h0);
    check(pslverr, 1'b1);
    $display("reset test done");
    cfg(0, 5);
    go(4'h1, 4'h1, 5);
    rd(12'h004, 32'hf, raw_m);
    apb(1'b1, 12'h008, 32'h1);
    rd(12'h00c, 32'hf, 32'h1);
    check(irq, 4'h1);
    apb(1'b1, 12'h00c, 32'h0);
    rd(12'h004, 32'hf, raw_m);
    apb(1'b1, 12'h00c, 32'hf);
    rd(12'h004, 32'hf, 32'h0);
    drain(0);
    $display("sequence test done");
    lat <= 3'($random(seed));
    apb(1'b1, 12'h020, 32'h3012);
    apb(1'b1, 12'h014, 32'h10);
    cfg(1, 4);
    cfg(2, 1);
    trig_in <= 4'h1;
    repeat (4) @(posedge pclk);
    trig_in <= 4'h0;
    t0 = starts;
    go(4'h6, 4'h4, 5);
    check(pos_q[t0], exp_q[2][0] >> 4 & 15);
    rd(12'h06c, 32'h1100, 32'h1000);
    drain(1);
    drain(2);
    $display("priority test done");
    apb(1'b1, 12'h030, 32'h2);
    cfg(3, 1);
    go(4'h8, 4'h8, 4);
    apb(1'b1, 12'h030, 32'h0);
    cfg(3, 1);
    go(4'h8, 4'h8, 1);
    rd(12'h010, 32'hf, ovf_m);
    apb(1'b1, 12'h010, 32'hf);
    drain(3);
    apb(1'b1, 12'h014, 32'hf000);
    cfg(3, 1);
    t0 = starts;
    apb(1'b1, 12'h000, 32'h8);
    repeat (100) @(posedge pclk);
    check(starts - t0 > 2, 1'b1);
    apb(1'b1, 12'h000, 32'h0);
    repeat (20) @(posedge pclk);
    drain(3);
    $display("averaging test done");
    results;
  end
endmodule // testbench
`default_nettype wire
